// ===== mode_ctrl_defines.vh
// Constants for the dual switch operating-mode controller.
// Assumes a 40 MHz system clock and a classic Wishbone register bus.
`ifndef MODE_CTRL_DEFINES_VH
`define MODE_CTRL_DEFINES_VH

// Clock rate and documented times.
`define CLK_KHZ 40000
`define WDT_TIMEOUT_MS 310
`define WDT_TIMEOUT_CYC (`WDT_TIMEOUT_MS * `CLK_KHZ)
`define IDLE_TIMEOUT_MS 250
`define IDLE_TIMEOUT_CYC (`IDLE_TIMEOUT_MS * `CLK_KHZ)
`define WAKE_SETTLE_US 50
`define WAKE_SETTLE_CYC ((`WAKE_SETTLE_US * `CLK_KHZ + 999) / 1000)

// Modulation: 256 steps per period, period no shorter than 1 ms.
`define PWM_MAX_HZ 1000
`define PWM_STEPS 256
`define PWM_STEP_HZ (`PWM_MAX_HZ * `PWM_STEPS)
`define PWM_BASE_DIV ((`CLK_KHZ * 1000 + `PWM_STEP_HZ - 1) / `PWM_STEP_HZ)

// Operating modes.
`define MODE_SLEEP 2'h0
`define MODE_NORMAL 2'h1
`define MODE_FAILSAFE 2'h2
`define MODE_FAULT 2'h3

// Register word indices (byte address = index * 4).
`define REG_GLOBAL_CONFIG 3'h0
`define REG_GLOBAL_STATUS 3'h1
`define REG_PULSE_WIDTH_A 3'h2
`define REG_PULSE_WIDTH_B 3'h3
`define REG_CHAN_CONFIG_A 3'h4
`define REG_CHAN_CONFIG_B 3'h5
`define REG_OVERCURRENT_A 3'h6
`define REG_OVERCURRENT_B 3'h7

// Global config fields.
`define GCR_SUPPLY_LOSS_EN 0
`define GCR_OV_GATE 1
`define GCR_WD_DISABLE 4
`define GCR_RESET 8'h02

// Channel config fields.
`define CCR_ON 0
`define CCR_PWM_EN 1
`define CCR_EXT_CLK 2
`define CCR_DIR_DIS 3
`define CCR_PRESC_LSB 4
`define CCR_RESET 8'h00

// Pulse width: duty in 7:0, turn-on delay in 15:8.
`define PWR_RESET 16'h0000
`define OCR_RESET 8'h00

`endif

// ===== input_activity.v
// Direct input synchroniser, edge detector and idle timeout.
// Assumes a free running system clock and a synchronous reset.
`timescale 1ns/1ps
`include "mode_ctrl_defines.vh"

module input_activity #(
    parameter [31:0] IDLE_CYC = `IDLE_TIMEOUT_CYC
) (
    // Clock and reset
    input wire clk_i,
    input wire rst_i,
    // Pin and enable
    input wire pin_i,
    input wire arm_i,
    // Results
    output wire level_o,
    output wire active_o
);

reg sync1_reg;
reg sync2_reg;
reg prev_reg;
reg active_reg;
reg [23:0] idle_reg;
wire rise;

assign rise = sync2_reg & ~prev_reg;
assign level_o = sync2_reg;
assign active_o = active_reg;

always @(posedge clk_i) begin
    if (rst_i) begin
        sync1_reg <= 1'b0;
        sync2_reg <= 1'b0;
        prev_reg <= 1'b0;
        active_reg <= 1'b0;
        idle_reg <= 24'h000000;
    end else begin
        sync1_reg <= pin_i;
        sync2_reg <= sync1_reg;
        prev_reg <= sync2_reg;
        // Idle time counts only while the input stays low.
        if (sync2_reg) begin
            idle_reg <= 24'h000000;
        end else if ({8'h00, idle_reg} < IDLE_CYC) begin
            idle_reg <= idle_reg + 24'h000001;
        end
        if (rise && arm_i) begin
            active_reg <= 1'b1;
        end else if (!sync2_reg && {8'h00, idle_reg} >= IDLE_CYC) begin
            active_reg <= 1'b0;
        end
    end
end

endmodule // input_activity

// ===== mode_controller.v
// Operating-mode controller of a dual channel high side switch.
// Assumes synchronous fault and supply flags, parallel serial words,
// and a classic Wishbone master on the register port.
// Functional notes
// - Mode: sleep, normal, fail-safe or fault from wake, fail-safe, fault.
// - Wake term is reset input OR either input activity flag.
// - Fail-safe on logic supply loss when enabled, or watchdog timeout.
// - Fault term ORs channel faults, undervoltage and gated overvoltage.
// - Watchdog disable bit 4 of global config blocks timeout fail-safe.
// - Input low longer than 250 ms clears that activity flag.
// - Both flags low and reset input low gives sleep.
// - Rising wake or direct input edge with supplies present gives normal.
// - Wake-up clears registers; functions available 50 us later.
// - Drive is input unless disabled, or on bit with duty when modulated.
// - Duty value comes from bits 7..0 of pulse width register.
// - Reset input low or fail-safe: channels follow direct inputs only.
// - Fault turns affected channels off; sleep turns all off.
// - Watchdog runs in normal with logic supply, enabled, wake high.
// - Normal mode flag readable and high while in normal mode.
// - Internal clock sets period; external clock sets frequency.
// - Modulation up to 1 kHz from internal or external clock.
// - Direct input mode follows input at once; turn-on delay only offsets modulation.
// - Pulse width, channel config, overcurrent registers per channel.
// - Top bit of every serial word is the watchdog toggle bit.
// - Fail-safe exit: word with toggle 1, second word within timeout.
// - Watchdog timeout counted from the internal clock.
`timescale 1ns/1ps
`include "mode_ctrl_defines.vh"

module mode_controller #(
    parameter [31:0] WDT_CYC = `WDT_TIMEOUT_CYC,
    parameter [31:0] IDLE_CYC = `IDLE_TIMEOUT_CYC
) (
    // Clock and reset
    input wire clk_i,
    input wire rst_i,
    // Wishbone slave
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [7:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output wire [31:0] wb_dat_o,
    output wire wb_ack_o,
    // Wake and direct inputs
    input wire wake_reset_input_n_i,
    input wire dir_in_a_i,
    input wire dir_in_b_i,
    input wire ext_clock_i,
    // Received serial words
    input wire word_valid_i,
    input wire [15:0] word_data_i,
    // Supplies and faults
    input wire power_supply_ok_i,
    input wire logic_supply_ok_i,
    input wire [1:0] overcurrent_fault_i,
    input wire [1:0] overtemperature_fault_i,
    input wire [1:0] severe_short_fault_i,
    input wire undervoltage_fault_i,
    input wire overvoltage_fault_i,
    // Outputs
    output wire switch_output_a_o,
    output wire switch_output_b_o,
    output wire failsafe_output_n_o,
    output wire normal_mode_flag_o,
    output wire [1:0] mode_o
);

// Modulation phase hit, with the turn-on delay as phase offset.
function duty_hit;
    input [7:0] phase;
    input [7:0] delay;
    input [7:0] duty;
    reg [7:0] shifted;
    begin
        shifted = phase - delay;
        duty_hit = (shifted < duty);
    end
endfunction

// Internal modulation tick period for a prescaler value.
function [15:0] tick_limit;
    input [3:0] presc;
    reg [31:0] prod;
    begin
        prod = `PWM_BASE_DIV * ({28'h0000000, presc} + 32'h00000001);
        tick_limit = prod[15:0] - 16'h0001;
    end
endfunction

reg wk_s1_reg, wk_s2_reg, wk_s3_reg, wake_prev_reg;
reg ext_s1_reg, ext_s2_reg, ext_s3_reg;
reg [1:0] mode_reg, mode_next;
reg [23:0] wdt_cnt_reg, exit_cnt_reg;
reg wdt_expired_reg, toggle_prev_reg, exit_arm_reg;
reg vdd_seen_reg, vdd_lost_reg, ready_reg;
reg [11:0] settle_reg;
reg [7:0] gcr_reg;
reg [15:0] pwr_reg [0:1], presc_cnt_reg [0:1];
reg [7:0] ccr_reg [0:1], ocr_reg [0:1], phase_reg [0:1];
reg ack_reg, drive_a_reg, drive_b_reg, fs_n_reg, nm_reg;
reg [31:0] dat_reg, rd_next;
wire lvl_a, lvl_b, act_a, act_b;
wire wake_term, wake_rise, wk_rise, failsafe_term, fault_term;
wire wdt_run, word_toggle, regs_clear, regs_live, ext_rise, req, ov_gated;
wire [1:0] chan_fault, hson, dir_lvl;
wire [2:0] idx;
integer i, j;
input_activity #(.IDLE_CYC(IDLE_CYC)) act_a_inst (
    .clk_i(clk_i), .rst_i(rst_i),
    .pin_i(dir_in_a_i),
    .arm_i(power_supply_ok_i),
    .level_o(lvl_a), .active_o(act_a)
);
input_activity #(.IDLE_CYC(IDLE_CYC)) act_b_inst (
    .clk_i(clk_i), .rst_i(rst_i),
    .pin_i(dir_in_b_i),
    .arm_i(power_supply_ok_i),
    .level_o(lvl_b), .active_o(act_b)
);
assign dir_lvl = {lvl_b, lvl_a};
assign wk_rise = wk_s2_reg & ~wk_s3_reg;
assign wake_term = wk_s2_reg | act_a | act_b;
assign wake_rise = wake_term & ~wake_prev_reg;
assign ov_gated = overvoltage_fault_i & gcr_reg[`GCR_OV_GATE];
assign fault_term = (|overcurrent_fault_i) | (|overtemperature_fault_i) |
    (|severe_short_fault_i) | undervoltage_fault_i | ov_gated;
assign chan_fault = overcurrent_fault_i | overtemperature_fault_i |
    severe_short_fault_i | {2{undervoltage_fault_i | ov_gated}};
// The expired flag survives the register clear of fail-safe mode.
assign failsafe_term = vdd_lost_reg |
    (wdt_expired_reg & ~gcr_reg[`GCR_WD_DISABLE]);
assign wdt_run = (mode_reg == `MODE_NORMAL) & logic_supply_ok_i &
    ~gcr_reg[`GCR_WD_DISABLE] & wk_s2_reg;
assign word_toggle = word_data_i[15];
assign regs_clear = wake_rise | (mode_reg == `MODE_SLEEP) |
    (mode_reg == `MODE_FAILSAFE);
assign regs_live = (mode_reg == `MODE_NORMAL) & wk_s2_reg & ready_reg;
assign ext_rise = ext_s2_reg & ~ext_s3_reg;
assign req = wb_cyc_i & wb_stb_i;
assign idx = wb_adr_i[4:2];

assign wb_dat_o = dat_reg;
assign wb_ack_o = ack_reg;
assign switch_output_a_o = drive_a_reg;
assign switch_output_b_o = drive_b_reg;
assign failsafe_output_n_o = fs_n_reg;
assign normal_mode_flag_o = nm_reg;
assign mode_o = mode_reg;

// Mode decode from the three terms.
always @* begin
    if (!wake_term) begin
        mode_next = `MODE_SLEEP;
    end else if (fault_term) begin
        mode_next = `MODE_FAULT;
    end else if (failsafe_term) begin
        mode_next = `MODE_FAILSAFE;
    end else begin
        mode_next = `MODE_NORMAL;
    end
end

// Synchronisers, mode, supply-loss tracking and wake settle time.
always @(posedge clk_i) begin
    if (rst_i) begin
        wk_s1_reg <= 1'b0;
        wk_s2_reg <= 1'b0;
        wk_s3_reg <= 1'b0;
        wake_prev_reg <= 1'b0;
        ext_s1_reg <= 1'b0;
        ext_s2_reg <= 1'b0;
        ext_s3_reg <= 1'b0;
        mode_reg <= `MODE_SLEEP;
        vdd_seen_reg <= 1'b0;
        vdd_lost_reg <= 1'b0;
        settle_reg <= 12'h000;
        ready_reg <= 1'b0;
    end else begin
        wk_s1_reg <= wake_reset_input_n_i;
        wk_s2_reg <= wk_s1_reg;
        wk_s3_reg <= wk_s2_reg;
        wake_prev_reg <= wake_term;
        ext_s1_reg <= ext_clock_i;
        ext_s2_reg <= ext_s1_reg;
        ext_s3_reg <= ext_s2_reg;
        mode_reg <= mode_next;
        if (logic_supply_ok_i) begin
            vdd_seen_reg <= 1'b1;
            vdd_lost_reg <= 1'b0;
        end else if (vdd_seen_reg && gcr_reg[`GCR_SUPPLY_LOSS_EN]) begin
            vdd_lost_reg <= 1'b1;
        end
        if (wake_rise || !wake_term) begin
            settle_reg <= 12'h000;
            ready_reg <= 1'b0;
        end else if (settle_reg == `WAKE_SETTLE_CYC - 1) begin
            ready_reg <= 1'b1;
        end else begin
            settle_reg <= settle_reg + 12'h001;
        end
    end
end

// Serial watchdog and the fail-safe exit sequence.
always @(posedge clk_i) begin
    if (rst_i) begin
        wdt_cnt_reg <= 24'h000000;
        wdt_expired_reg <= 1'b0;
        toggle_prev_reg <= 1'b0;
        exit_arm_reg <= 1'b0;
        exit_cnt_reg <= 24'h000000;
    end else begin
        if (word_valid_i) begin
            toggle_prev_reg <= word_toggle;
        end
        if (wk_rise) begin
            wdt_cnt_reg <= 24'h000000;
        end else if (word_valid_i && word_toggle != toggle_prev_reg) begin
            wdt_cnt_reg <= 24'h000000;
        end else if (wdt_run) begin
            if ({8'h00, wdt_cnt_reg} >= WDT_CYC - 32'h00000001) begin
                wdt_expired_reg <= 1'b1;
            end else begin
                wdt_cnt_reg <= wdt_cnt_reg + 24'h000001;
            end
        end
        if (mode_reg != `MODE_FAILSAFE) begin
            exit_arm_reg <= 1'b0;
            exit_cnt_reg <= 24'h000000;
        end else if (exit_arm_reg) begin
            if (word_valid_i) begin
                wdt_expired_reg <= 1'b0;
                wdt_cnt_reg <= 24'h000000;
                exit_arm_reg <= 1'b0;
            end else if ({8'h00, exit_cnt_reg} >= WDT_CYC - 32'h00000001) begin
                exit_arm_reg <= 1'b0;
            end else begin
                exit_cnt_reg <= exit_cnt_reg + 24'h000001;
            end
        end else if (word_valid_i && word_toggle) begin
            exit_arm_reg <= 1'b1;
            exit_cnt_reg <= 24'h000000;
        end
    end
end

// Read mux.
always @* begin
    rd_next = 32'h00000000;
    if (wb_adr_i[7:5] == 3'h0) begin
        case (idx)
            `REG_GLOBAL_CONFIG: rd_next = {24'h000000, gcr_reg};
            `REG_GLOBAL_STATUS: rd_next = {22'h000000, drive_b_reg,
                drive_a_reg, ready_reg, act_b, act_a, vdd_lost_reg,
                wdt_expired_reg, nm_reg, mode_reg};
            `REG_PULSE_WIDTH_A: rd_next = {16'h0000, pwr_reg[0]};
            `REG_PULSE_WIDTH_B: rd_next = {16'h0000, pwr_reg[1]};
            `REG_CHAN_CONFIG_A: rd_next = {24'h000000, ccr_reg[0]};
            `REG_CHAN_CONFIG_B: rd_next = {24'h000000, ccr_reg[1]};
            `REG_OVERCURRENT_A: rd_next = {24'h000000, ocr_reg[0]};
            `REG_OVERCURRENT_B: rd_next = {24'h000000, ocr_reg[1]};
            default: rd_next = 32'h00000000;
        endcase
    end
end

// Bus handshake and register writes; a write lands on the edge that ends the ack cycle.
always @(posedge clk_i) begin
    if (rst_i) begin
        ack_reg <= 1'b0;
        dat_reg <= 32'h00000000;
    end else begin
        ack_reg <= req & ~ack_reg;
        dat_reg <= (req & ~ack_reg) ? rd_next : 32'h00000000;
    end
end

always @(posedge clk_i) begin
    if (rst_i || regs_clear) begin
        gcr_reg <= `GCR_RESET;
        for (j = 0; j < 2; j = j + 1) begin
            pwr_reg[j] <= `PWR_RESET;
            ccr_reg[j] <= `CCR_RESET;
            ocr_reg[j] <= `OCR_RESET;
        end
    end else if (req && ack_reg && wb_we_i && wb_adr_i[7:5] == 3'h0) begin
        case (idx)
            `REG_GLOBAL_CONFIG: if (wb_sel_i[0]) gcr_reg <= wb_dat_i[7:0];
            `REG_PULSE_WIDTH_A, `REG_PULSE_WIDTH_B: begin
                if (wb_sel_i[0]) pwr_reg[idx[0]][7:0] <= wb_dat_i[7:0];
                if (wb_sel_i[1]) pwr_reg[idx[0]][15:8] <= wb_dat_i[15:8];
            end
            `REG_CHAN_CONFIG_A, `REG_CHAN_CONFIG_B: begin
                if (wb_sel_i[0]) ccr_reg[idx[0]] <= wb_dat_i[7:0];
            end
            `REG_OVERCURRENT_A, `REG_OVERCURRENT_B: begin
                if (wb_sel_i[0]) ocr_reg[idx[0]] <= wb_dat_i[7:0];
            end
            default: begin
            end
        endcase
    end
end

// Modulation phase per channel, internal or external period.
always @(posedge clk_i) begin
    for (i = 0; i < 2; i = i + 1) begin
        if (rst_i || !ccr_reg[i][`CCR_PWM_EN]) begin
            presc_cnt_reg[i] <= 16'h0000;
            phase_reg[i] <= 8'h00;
        end else if (ccr_reg[i][`CCR_EXT_CLK]) begin
            if (ext_rise) begin
                presc_cnt_reg[i] <= 16'h0000;
                phase_reg[i] <= 8'h00;
            end else if (presc_cnt_reg[i] == tick_limit(4'h0)) begin
                presc_cnt_reg[i] <= 16'h0000;
                if (phase_reg[i] != 8'hff) begin
                    phase_reg[i] <= phase_reg[i] + 8'h01;
                end
            end else begin
                presc_cnt_reg[i] <= presc_cnt_reg[i] + 16'h0001;
            end
        end else if (presc_cnt_reg[i] ==
            tick_limit(ccr_reg[i][`CCR_PRESC_LSB +: 4])) begin
            presc_cnt_reg[i] <= 16'h0000;
            phase_reg[i] <= phase_reg[i] + 8'h01;
        end else begin
            presc_cnt_reg[i] <= presc_cnt_reg[i] + 16'h0001;
        end
    end
end

// Drive targets; registers only steer while live in normal mode.
genvar g;
generate
    for (g = 0; g < 2; g = g + 1) begin : drive_gen
        assign hson[g] = (dir_lvl[g] & ~(regs_live &
            ccr_reg[g][`CCR_DIR_DIS])) |
            (regs_live & ccr_reg[g][`CCR_ON] & ccr_reg[g][`CCR_PWM_EN] &
            duty_hit(phase_reg[g], pwr_reg[g][15:8],
            pwr_reg[g][7:0])) |
            (regs_live & ccr_reg[g][`CCR_ON] & ~ccr_reg[g][`CCR_PWM_EN]);
    end
endgenerate

always @(posedge clk_i) begin
    if (rst_i) begin
        drive_a_reg <= 1'b0;
        drive_b_reg <= 1'b0;
        fs_n_reg <= 1'b1;
        nm_reg <= 1'b0;
    end else begin
        drive_a_reg <= hson[0] & (mode_next != `MODE_SLEEP) &
            ~chan_fault[0];
        drive_b_reg <= hson[1] & (mode_next != `MODE_SLEEP) &
            ~chan_fault[1];
        fs_n_reg <= (mode_next != `MODE_FAILSAFE);
        nm_reg <= (mode_next == `MODE_NORMAL);
    end
end

endmodule // mode_controller

// ===== mode_controller_checker.sv
// Port assertions for the operating-mode controller.
// Assumes it is bound to every mode_controller instance.
`timescale 1ns/1ps
`include "mode_ctrl_defines.vh"
module mode_controller_checker #(
    parameter [31:0] WDT_CYC = 200,
    parameter [31:0] IDLE_CYC = 100
) (
    // Clock and reset
    input wire clk_i,
    input wire rst_i,
    // Register bus
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire wb_ack_o,
    input wire [31:0] wb_dat_o,
    // Wake and faults
    input wire wake_reset_input_n_i,
    input wire undervoltage_fault_i,
    // Outputs
    input wire switch_output_a_o,
    input wire switch_output_b_o,
    input wire failsafe_output_n_o,
    input wire normal_mode_flag_o,
    input wire [1:0] mode_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    wire req = wb_cyc_i && wb_stb_i;
    ack_next_a: assert property (req && !wb_ack_o |=> wb_ack_o)
        else $error("bus request not answered next cycle");
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("bus answer longer than one cycle");
    dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data outside an answer");
    fs_pin_a: assert property (failsafe_output_n_o ==
        (mode_o != `MODE_FAILSAFE))
        else $error("fail-safe pin disagrees with mode");
    nm_flag_a: assert property (normal_mode_flag_o ==
        (mode_o == `MODE_NORMAL))
        else $error("normal flag disagrees with mode");
    sleep_off_a: assert property ((mode_o == `MODE_SLEEP) [*3]
        |-> !switch_output_a_o && !switch_output_b_o)
        else $error("channel driven in sleep");
    uv_fault_a: assert property ((undervoltage_fault_i &&
        mode_o != `MODE_SLEEP) [*3] |-> mode_o == `MODE_FAULT)
        else $error("undervoltage did not give fault mode");
    uv_off_a: assert property (undervoltage_fault_i [*4]
        |-> !switch_output_a_o && !switch_output_b_o)
        else $error("channel driven during undervoltage");
    wake_up_a: assert property (wake_reset_input_n_i [*5]
        |-> mode_o != `MODE_SLEEP)
        else $error("sleep while wake input high");
    cover property (mode_o == `MODE_FAILSAFE);
    cover property (mode_o == `MODE_FAULT);
    cover property (req && wb_we_i && wb_ack_o);
endmodule // mode_controller_checker
bind mode_controller mode_controller_checker #(.WDT_CYC(WDT_CYC),
    .IDLE_CYC(IDLE_CYC)) mode_controller_checker_i (.clk_i(clk_i),
    .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o),
    .wake_reset_input_n_i(wake_reset_input_n_i),
    .undervoltage_fault_i(undervoltage_fault_i),
    .switch_output_a_o(switch_output_a_o),
    .switch_output_b_o(switch_output_b_o),
    .failsafe_output_n_o(failsafe_output_n_o),
    .normal_mode_flag_o(normal_mode_flag_o), .mode_o(mode_o));

// ===== host_model.sv
// Host model that hands received serial words to the controller.
// Assumes keep_i held for regular traffic and shot_i pulsed one cycle.
`timescale 1ns/1ps
module host_model #(
    parameter int GAP = 50
) (
    // Clock and reset
    input wire clk_i,
    input wire rst_i,
    // Commands
    input wire keep_i,
    input wire shot_i,
    // Serial words
    output logic word_valid_o,
    output logic [15:0] word_data_o
);
    logic [7:0] cnt_reg;
    logic tog_reg;
    always @(posedge clk_i) begin
        if (rst_i) begin
            cnt_reg <= 8'h00;
            tog_reg <= 1'b0;
            word_valid_o <= 1'b0;
            word_data_o <= 16'h0000;
        end else if (shot_i || (keep_i && cnt_reg == GAP)) begin
            // Top bit alternates; a shot forces it to one.
            tog_reg <= shot_i | ~tog_reg;
            word_valid_o <= 1'b1;
            word_data_o <= {shot_i | ~tog_reg, 15'h0a5a};
            cnt_reg <= 8'h00;
        end else begin
            // Between words the lines carry nothing stable.
            word_valid_o <= 1'b0;
            word_data_o <= ~word_data_o;
            cnt_reg <= keep_i ? cnt_reg + 8'h01 : 8'h00;
        end
    end
endmodule // host_model

// ===== mode_controller_test.sv
// Self-checking bench for the operating-mode controller.
// Assumes short timeouts and the host word model on the serial side.
`timescale 1ns/1ps
`include "mode_ctrl_defines.vh"
module mode_controller_test;
    localparam int WDT = 200;
    localparam int IDLE = 100;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0;
    logic wake = 1'b0;
    logic in_a = 1'b0;
    logic in_b = 1'b0;
    logic lsup = 1'b1;
    logic [7:0] fv = 8'h00;
    logic keep = 1'b0;
    logic shot = 1'b0;
    logic ext = 1'b0;
    logic [31:0] q;
    wire [31:0] rdat;
    wire ack, wvld, sw_a, sw_b, fs_n, nm;
    wire [15:0] wword;
    wire [1:0] mode;
    int n_fail = 0;
    int cmp_count = 0;
    always #12.5 clk_i = ~clk_i;
    host_model host_model_i (.clk_i(clk_i), .rst_i(rst_i), .keep_i(keep),
        .shot_i(shot), .word_valid_o(wvld), .word_data_o(wword));
    mode_controller #(.WDT_CYC(WDT), .IDLE_CYC(IDLE)) mode_controller_i (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .wake_reset_input_n_i(wake),
        .dir_in_a_i(in_a), .dir_in_b_i(in_b), .ext_clock_i(ext),
        .word_valid_i(wvld), .word_data_i(wword), .power_supply_ok_i(1'b1),
        .logic_supply_ok_i(lsup), .overcurrent_fault_i(fv[1:0]),
        .overtemperature_fault_i(fv[3:2]), .severe_short_fault_i(fv[5:4]),
        .undervoltage_fault_i(fv[6]), .overvoltage_fault_i(fv[7]),
        .switch_output_a_o(sw_a), .switch_output_b_o(sw_b),
        .failsafe_output_n_o(fs_n), .normal_mode_flag_o(nm), .mode_o(mode));
    task automatic close_out;
        $display("checks %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] seen, exp);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic give_up(input string what);
        n_fail++;
        $display("[FAIL] %s expected done seen timeout", what);
        close_out();
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    task automatic bus(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do begin
            tick(1);
            n++;
        end while (ack !== 1'b1 && n < 20);
        q = rdat;
        @(posedge clk_i);
        cyc <= 1'b0;
        if (n >= 20) give_up("bus answer");
    endtask
    task automatic wait_mode(input logic [1:0] m, input int lim);
        int n;
        n = 0;
        tick(1);
        while (mode !== m && n < lim) begin
            tick(1);
            n++;
        end
        chk("mode", mode, m);
        if (mode !== m) close_out();
    endtask
    task automatic t_reset;
        tick(1);
        chk("mode", mode, `MODE_SLEEP);
        chk("fail-safe pin", fs_n, 1'b1);
        bus(1'b1, 8'h10, 32'h01);
        bus(1'b0, 8'h10, 32'h0);
        chk("write in sleep", q, 32'h0);
        bus(1'b0, 8'h00, 32'h0);
        chk("global config", q, 32'h02);
        bus(1'b0, 8'h20, 32'h0);
        chk("unmapped read", q, 32'h0);
        $display("test reset done");
    endtask
    task automatic t_wake;
        @(posedge clk_i);
        keep <= 1'b1;
        wake <= 1'b1;
        wait_mode(`MODE_NORMAL, 10);
        chk("normal flag", nm, 1'b1);
        tick(2010);
        bus(1'b0, 8'h04, 32'h0);
        chk("status mode", q & 32'h7, 32'h5);
        $display("test wake done");
    endtask
    task automatic t_drive;
        bus(1'b1, 8'h10, 32'h01);
        tick(3);
        chk("on bit drive", sw_a, 1'b1);
        bus(1'b1, 8'h10, 32'h03);
        tick(3);
        repeat (20) begin
            tick(1);
            chk("zero duty", sw_a, 1'b0);
        end
        bus(1'b1, 8'h14, 32'h08);
        @(posedge clk_i);
        in_a <= 1'b1;
        in_b <= 1'b1;
        tick(6);
        chk("direct drive", sw_a, 1'b1);
        chk("direct disable", sw_b, 1'b0);
        @(posedge clk_i);
        in_a <= 1'b0;
        in_b <= 1'b0;
        bus(1'b0, 8'h10, 32'h0);
        chk("config read", q, 32'h03);
        bus(1'b1, 8'h08, 32'h01);
        bus(1'b0, 8'h08, 32'h0);
        chk("pulse width read", q, 32'h01);
        bus(1'b1, 8'h10, 32'h07);
        tick(200);
        chk("duty one off", sw_a, 1'b0);
        @(posedge clk_i);
        ext <= 1'b1;
        @(posedge clk_i);
        ext <= 1'b0;
        tick(6);
        chk("ext restart", sw_a, 1'b1);
        $display("test drive done");
    endtask
    task automatic t_wdog;
        @(posedge clk_i);
        keep <= 1'b0;
        tick(WDT - 80);
        chk("before expiry", mode, `MODE_NORMAL);
        wait_mode(`MODE_FAILSAFE, 150);
        chk("fail-safe pin", fs_n, 1'b0);
        @(posedge clk_i);
        in_a <= 1'b1;
        tick(6);
        chk("fail-safe direct", sw_a, 1'b1);
        @(posedge clk_i);
        in_a <= 1'b0;
        shot <= 1'b1;
        @(posedge clk_i);
        shot <= 1'b0;
        keep <= 1'b1;
        wait_mode(`MODE_NORMAL, 120);
        bus(1'b1, 8'h00, 32'h12);
        @(posedge clk_i);
        keep <= 1'b0;
        tick(2 * WDT);
        chk("watchdog off", mode, `MODE_NORMAL);
        @(posedge clk_i);
        keep <= 1'b1;
        bus(1'b1, 8'h00, 32'h03);
        @(posedge clk_i);
        lsup <= 1'b0;
        wait_mode(`MODE_FAILSAFE, 10);
        @(posedge clk_i);
        lsup <= 1'b1;
        wait_mode(`MODE_NORMAL, 120);
        $display("test watchdog done");
    endtask
    task automatic t_fault;
        for (int i = 0; i < 8; i++) begin
            @(posedge clk_i);
            fv <= 8'h01 << i;
            wait_mode(`MODE_FAULT, 10);
            @(posedge clk_i);
            fv <= 8'h00;
            wait_mode(`MODE_NORMAL, 10);
        end
        bus(1'b1, 8'h00, 32'h00);
        @(posedge clk_i);
        fv <= 8'h80;
        tick(6);
        chk("gated overvoltage", mode, `MODE_NORMAL);
        @(posedge clk_i);
        fv <= 8'h00;
        $display("test fault done");
    endtask
    task automatic t_sleep;
        @(posedge clk_i);
        keep <= 1'b0;
        wake <= 1'b0;
        wait_mode(`MODE_SLEEP, 20);
        @(posedge clk_i);
        in_b <= 1'b1;
        wait_mode(`MODE_NORMAL, 10);
        tick(3);
        chk("wake by input", sw_b, 1'b1);
        @(posedge clk_i);
        in_b <= 1'b0;
        tick(IDLE - 20);
        chk("flag holds", mode, `MODE_NORMAL);
        wait_mode(`MODE_SLEEP, 40);
        chk("sleep drive", sw_b, 1'b0);
        $display("test sleep done");
    endtask
    initial begin
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_wake();
        t_drive();
        t_wdog();
        t_fault();
        t_sleep();
        close_out();
    end
endmodule // mode_controller_test
